/* hdl/spr_map.svh */
`ifndef SPR_MAP_SVH
`define SPR_MAP_SVH

// ==========================================================
// Register byte offsets.
`define SPR_ADR_CTRL      8'h00
`define SPR_ADR_SP1       8'h04
`define SPR_ADR_SP4       8'h10
`define SPR_ADR_MAKE      8'h14
`define SPR_ADR_BREAK     8'h18
`define SPR_ADR_CAL_LO    8'h1C
`define SPR_ADR_CAL_HI    8'h20
`define SPR_ADR_SPAN_BOT  8'h24
`define SPR_ADR_SPAN_TOP  8'h28
`define SPR_ADR_STATUS    8'h2C

// ==========================================================
// Reset values.
`define SPR_CTRL_RST      32'h0000_0F02
`define SPR_SP_RST        16'h270F
`define SPR_CAL_LO_RST    16'h0FA0
`define SPR_CAL_HI_RST    16'h4E20
`define SPR_SPAN_BOT_RST  16'h0000
`define SPR_SPAN_TOP_RST  16'h270F

// ==========================================================
// Calibration limits: microamps in current mode, millivolts in voltage mode; delay limit in seconds.
`define SPR_LO_MIN_UA     16'h012C
`define SPR_MID_UA        16'h4650
`define SPR_HI_MAX_UA     16'h5DC0
`define SPR_LO_MIN_MV     16'hFDA8
`define SPR_MID_MV        16'h1F40
`define SPR_HI_MAX_MV     16'h283C
`define SPR_DELAY_MAX     14'h270F

// ==========================================================
// Timing.
`define SPR_SECOND_NS     1000000000
`define SPR_CLK_PERIOD_NS 10

`endif

/* hdl/spr_pkg.sv */
package spr_pkg;

   // Bar colour codes.
   typedef enum logic [1:0] {
      SPR_GREEN  = 2'h0,
      SPR_ORANGE = 2'h1,
      SPR_RED    = 2'h2
   } spr_col_t;

   // Polarity editor states.
   typedef enum logic [1:0] {
      SPR_ED_IDLE = 2'h1,
      SPR_ED_EDIT = 2'h2
   } spr_ed_t;

   // Control word layout.
   typedef struct packed {
      logic [9:0]           rsvd;
      spr_col_t [3:0]       sp_col;
      spr_col_t             base_col;
      logic [3:0]           pol_high;
      logic [3:0]           band_en;
      logic                 out_volt;
      logic                 fill_empty;
      logic                 readout_on;
      logic                 center;
   } spr_ctrl_t;

   // Status word layout.
   typedef struct packed {
      logic [18:0]          rsvd;
      logic                 cal_reject;
      logic                 readout_lit;
      spr_col_t             colour;
      logic [3:0]           relay;
      logic [3:0]           alarm;
      logic                 out_fitted;
   } spr_stat_t;

endpackage

/* hdl/spr_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
`include "spr_map.svh"

module spr_ctrl
   import spr_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = `SPR_SECOND_NS / `SPR_CLK_PERIOD_NS
) (
   // Clock and reset.
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // Wishbone slave.
   input  wire logic               cyc_i,
   input  wire logic               stb_i,
   input  wire logic               we_i,
   input  wire logic [7:0]         adr_i,
   input  wire logic [3:0]         sel_i,
   input  wire logic [31:0]        dat_i,
   output logic      [31:0]        dat_o,
   output logic                    ack_o,
   // Reading source.
   input  wire logic               rdg_valid_i,
   input  wire logic signed [15:0] rdg_i,
   // Front panel and module detect.
   input  wire logic               btn_press_i,
   input  wire logic               proc_done_i,
   input  wire logic               pol_edit_start_i,
   input  wire logic               pol_flip_i,
   input  wire logic               pol_next_i,
   input  wire logic               out_fitted_i,
   // Relays, display and output.
   output logic      [3:0]         relay_o,
   output logic      [3:0]         led_o,
   output spr_col_t                bar_col_o,
   output logic                    bar_center_o,
   output logic                    bar_up_o,
   output logic                    readout_on_o,
   output logic      [3:0]         edit_digit_o,
   output logic                    skip_out_cal_o,
   output logic signed [15:0]      out_level_o
);

   // ==========================================================
   // Register storage.
   spr_ctrl_t               ctrl_ff;         // Control word.
   logic signed [15:0]      sp_ff [4];       // Setpoints one to four.
   logic        [13:0]      make_ff;         // Make delay in seconds.
   logic        [13:0]      break_ff;        // Break delay in seconds.
   logic signed [15:0]      cal_lo_ff;       // Low output level.
   logic signed [15:0]      cal_hi_ff;       // High output level.
   logic signed [15:0]      bot_ff;          // Reading at low level.
   logic signed [15:0]      top_ff;          // Reading at high level.
   logic                    cal_rej_ff;      // Last calibration write refused.
   logic                    ack_ff;          // Bus acknowledge.
   logic        [31:0]      dat_ff;          // Read data.
   spr_ed_t                 ed_ff;           // Polarity editor state.
   logic        [1:0]       ed_idx_ff;       // Digit under edit.
   logic                    view_ff;         // Panel procedure in progress.
   logic                    cap_done_ff;     // Module detect taken.
   logic                    fitted_ff;       // Output module present.
   logic        [3:0]       alarm_ff;        // Per-setpoint alarm.
   logic                    raw1_ff;         // Setpoint one wanted state.
   logic        [31:0]      sec_cnt_ff;      // Second prescaler.
   logic        [13:0]      dly_cnt_ff;      // Elapsed delay seconds.
   spr_col_t                col_ff;          // Bar zone colour.
   logic                    bar_up_ff;       // Bar direction.
   logic                    relay1_ff;       // Setpoint one relay.
   logic        [3:1]       relay_ff;        // Undelayed relays.
   logic                    readout_ff;      // Digits lit.
   logic signed [15:0]      level_ff;        // Output level.

   // ==========================================================
   // Bus decode.
   logic                    req;             // New access this cycle.
   logic                    wr;              // Write strobe.

   assign req = cyc_i && stb_i && !ack_ff;
   assign wr  = req && we_i;

   // Byte-lane merge of a write into an old word.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return res;
   endfunction

   // Offset match for a given register.
   function automatic logic hit(input logic [7:0] adr, input logic [7:0] reg_adr);
      return adr[7:2] == reg_adr[7:2];
   endfunction

   // Ack one cycle after the request; dropped the following cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req;
      end
   end

   // ==========================================================
   // Calibration limit checks on the merged write value.
   logic [31:0]             cal_new;
   logic signed [15:0]      cal_v;
   logic                    lo_ok;
   logic                    hi_ok;

   assign cal_new = merge(32'(hit(adr_i, `SPR_ADR_CAL_LO) ? cal_lo_ff : cal_hi_ff), dat_i, sel_i);
   assign cal_v   = cal_new[15:0];
   assign lo_ok = (ctrl_ff.out_volt
                   ? (cal_v >= $signed(`SPR_LO_MIN_MV) && cal_v <= $signed(`SPR_MID_MV))
                   : (cal_v >= $signed(`SPR_LO_MIN_UA) && cal_v <= $signed(`SPR_MID_UA)))
                  && cal_v < cal_hi_ff;
   assign hi_ok = (ctrl_ff.out_volt
                   ? (cal_v >= $signed(`SPR_MID_MV) && cal_v <= $signed(`SPR_HI_MAX_MV))
                   : (cal_v >= $signed(`SPR_MID_UA) && cal_v <= $signed(`SPR_HI_MAX_UA)))
                  && cal_v > cal_lo_ff;

   // Control word: bus writes plus panel polarity edits; the edit is applied last.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff <= spr_ctrl_t'(`SPR_CTRL_RST);
      end else begin
         if (wr && hit(adr_i, `SPR_ADR_CTRL)) begin
            ctrl_ff <= spr_ctrl_t'(merge(32'(ctrl_ff), dat_i, sel_i) & 32'h003F_FFFF);
         end
         if (ed_ff == SPR_ED_EDIT && pol_flip_i) begin
            ctrl_ff.pol_high[ed_idx_ff] <= !ctrl_ff.pol_high[ed_idx_ff];
         end
      end
   end

   // Setpoints, one per generated slot.
   for (genvar g = 0; g < 4; g++) begin : g_sp
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            sp_ff[g] <= `SPR_SP_RST;
         end else if (wr && adr_i[7:2] == 6'(g + 1)) begin
            sp_ff[g] <= 16'(merge(32'(sp_ff[g]), dat_i, sel_i));
         end
      end
   end

   // Delays, spans and checked calibration levels.
   always_ff @(posedge clk_i) begin
      logic [31:0] v;
      v = merge(32'h0, dat_i, sel_i);
      if (rst_i) begin
         make_ff    <= 14'h0;
         break_ff   <= 14'h0;
         bot_ff     <= `SPR_SPAN_BOT_RST;
         top_ff     <= `SPR_SPAN_TOP_RST;
         cal_lo_ff  <= `SPR_CAL_LO_RST;
         cal_hi_ff  <= `SPR_CAL_HI_RST;
         cal_rej_ff <= 1'b0;
      end else if (wr) begin
         // Delays are clipped to their largest setting rather than refused.
         if (hit(adr_i, `SPR_ADR_MAKE)) begin
            make_ff <= (v[15:0] > 16'(`SPR_DELAY_MAX)) ? `SPR_DELAY_MAX : v[13:0];
         end else if (hit(adr_i, `SPR_ADR_BREAK)) begin
            break_ff <= (v[15:0] > 16'(`SPR_DELAY_MAX)) ? `SPR_DELAY_MAX : v[13:0];
         end else if (hit(adr_i, `SPR_ADR_SPAN_BOT)) begin
            bot_ff <= 16'(merge(32'(bot_ff), dat_i, sel_i));
         end else if (hit(adr_i, `SPR_ADR_SPAN_TOP)) begin
            top_ff <= 16'(merge(32'(top_ff), dat_i, sel_i));
         end else if (hit(adr_i, `SPR_ADR_CAL_LO)) begin
            // Out-of-range levels keep the old value so the output never jumps.
            if (lo_ok) begin
               cal_lo_ff <= cal_v;
            end
            cal_rej_ff <= !lo_ok;
         end else if (hit(adr_i, `SPR_ADR_CAL_HI)) begin
            if (hi_ok) begin
               cal_hi_ff <= cal_v;
            end
            cal_rej_ff <= !hi_ok;
         end
      end
   end

   // Read data, latched with the ack; unmapped offsets read zero.
   always_ff @(posedge clk_i) begin
      spr_stat_t st;
      st = '0;
      st.cal_reject  = cal_rej_ff;
      st.readout_lit = readout_ff;
      st.colour      = col_ff;
      st.relay       = {relay_ff, relay1_ff};
      st.alarm       = alarm_ff;
      st.out_fitted  = fitted_ff;
      if (rst_i) begin
         dat_ff <= 32'h0;
      end else if (req && !we_i) begin
         if (hit(adr_i, `SPR_ADR_CTRL)) begin
            dat_ff <= 32'(ctrl_ff);
         end else if (adr_i[7:2] >= 6'h01 && adr_i[7:2] <= 6'(`SPR_ADR_SP4 >> 2)) begin
            dat_ff <= {16'h0, sp_ff[2'(adr_i[7:2] - 6'h01)]};
         end else if (hit(adr_i, `SPR_ADR_MAKE)) begin
            dat_ff <= {18'h0, make_ff};
         end else if (hit(adr_i, `SPR_ADR_BREAK)) begin
            dat_ff <= {18'h0, break_ff};
         end else if (hit(adr_i, `SPR_ADR_CAL_LO)) begin
            dat_ff <= {16'h0, cal_lo_ff};
         end else if (hit(adr_i, `SPR_ADR_CAL_HI)) begin
            dat_ff <= {16'h0, cal_hi_ff};
         end else if (hit(adr_i, `SPR_ADR_SPAN_BOT)) begin
            dat_ff <= {16'h0, bot_ff};
         end else if (hit(adr_i, `SPR_ADR_SPAN_TOP)) begin
            dat_ff <= {16'h0, top_ff};
         end else if (hit(adr_i, `SPR_ADR_STATUS)) begin
            dat_ff <= 32'(st);
         end else begin
            dat_ff <= 32'h0;
         end
      end
   end

   // ==========================================================
   // Panel: polarity editor, readout relight and module detect.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ed_ff     <= SPR_ED_IDLE;
         ed_idx_ff <= 2'h0;
      end else begin
         case (ed_ff)
            SPR_ED_IDLE: begin
               if (pol_edit_start_i) begin
                  ed_ff     <= SPR_ED_EDIT;
                  ed_idx_ff <= 2'h0;
               end
            end
            SPR_ED_EDIT: begin
               // Digits run left to right, one to four, then editing ends.
               if (pol_next_i) begin
                  ed_idx_ff <= ed_idx_ff + 2'h1;
                  if (ed_idx_ff == 2'h3) begin
                     ed_ff <= SPR_ED_IDLE;
                  end
               end
            end
            default: begin
               ed_ff <= SPR_ED_IDLE;
            end
         endcase
      end
   end

   // A press and a finish in the same cycle keep the digits lit.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         view_ff    <= 1'b0;
         readout_ff <= 1'b1;
      end else begin
         view_ff    <= btn_press_i || (view_ff && !proc_done_i);
         readout_ff <= ctrl_ff.readout_on || btn_press_i || (view_ff && !proc_done_i);
      end
   end

   // The module strap is taken once, on the first edge after reset.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cap_done_ff <= 1'b0;
         fitted_ff   <= 1'b0;
      end else if (!cap_done_ff) begin
         cap_done_ff <= 1'b1;
         fitted_ff   <= out_fitted_i;
      end
   end

   // ==========================================================
   // Setpoint evaluation, done on every reading.
   logic [3:0]              alarm_nxt;
   logic                    band_on;
   logic                    nxt_raw1;
   spr_col_t                nxt_col;

   assign band_on = ctrl_ff.fill_empty && (sp_ff[1] > sp_ff[0]);

   always_comb begin
      logic signed [15:0] best;
      logic               any;
      best = 16'sh0;
      any  = 1'b0;
      // Extreme setpoints simply never trip; nothing else suppresses them.
      for (int i = 0; i < 4; i++) begin
         alarm_nxt[i] = ctrl_ff.pol_high[i] ? (rdg_i > sp_ff[i])
                                            : (rdg_i < sp_ff[i]);
      end
      // Band hysteresis on setpoint one holds its state between the limits.
      nxt_raw1 = alarm_nxt[0];
      if (band_on) begin
         if (!ctrl_ff.pol_high[0]) begin
            nxt_raw1 = (rdg_i < sp_ff[0]) || (raw1_ff && rdg_i < sp_ff[1]);
         end else begin
            nxt_raw1 = (rdg_i > sp_ff[1]) || (raw1_ff && rdg_i > sp_ff[0]);
         end
      end
      // Highest passed setpoint sets the colour; ascending scan lets ties go upward.
      nxt_col = ctrl_ff.base_col;
      for (int i = 0; i < 4; i++) begin
         if (rdg_i > sp_ff[i] && (!any || sp_ff[i] >= best)) begin
            nxt_col = ctrl_ff.sp_col[i];
            best    = sp_ff[i];
            any     = 1'b1;
         end
      end
   end

   // Latch comparisons, colour and bar direction on each reading.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         alarm_ff  <= 4'h0;
         raw1_ff   <= 1'b0;
         relay_ff  <= 3'h0;
         col_ff    <= SPR_GREEN;
         bar_up_ff <= 1'b1;
      end else if (rdg_valid_i) begin
         alarm_ff  <= alarm_nxt;
         raw1_ff   <= nxt_raw1;
         relay_ff  <= alarm_nxt[3:1];
         col_ff    <= nxt_col;
         bar_up_ff <= rdg_i >= 16'sh0;
      end
   end

   // ==========================================================
   // Setpoint one make and break delays, counted in whole seconds.
   logic [13:0]             dly_need;

   assign dly_need = raw1_ff ? make_ff : break_ff;

   // Any return to the relay state restarts the count from zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         relay1_ff  <= 1'b0;
         sec_cnt_ff <= 32'h0;
         dly_cnt_ff <= 14'h0;
      end else if (raw1_ff == relay1_ff) begin
         sec_cnt_ff <= 32'h0;
         dly_cnt_ff <= 14'h0;
      end else if (dly_cnt_ff >= dly_need) begin
         relay1_ff  <= raw1_ff;
         sec_cnt_ff <= 32'h0;
         dly_cnt_ff <= 14'h0;
      end else if (sec_cnt_ff == 32'(SEC_CYCLES - 1)) begin
         sec_cnt_ff <= 32'h0;
         dly_cnt_ff <= dly_cnt_ff + 14'h1;
      end else begin
         sec_cnt_ff <= sec_cnt_ff + 32'h1;
      end
   end

   // ==========================================================
   // Output scaling: linear through both points, floored at the low level.
   logic signed [16:0]      d_rdg;
   logic signed [16:0]      d_span;
   logic signed [16:0]      d_lev;
   logic signed [35:0]      lin;
   logic signed [15:0]      out_max;

   assign d_rdg   = 17'(rdg_i) - 17'(bot_ff);
   assign d_span  = 17'(top_ff) - 17'(bot_ff);
   assign d_lev   = 17'(cal_hi_ff) - 17'(cal_lo_ff);
   assign out_max = ctrl_ff.out_volt ? `SPR_HI_MAX_MV : `SPR_HI_MAX_UA;
   // A zero span cannot be divided; it pins the output at the low level.
   assign lin = (d_span == 17'sh0) ? 36'(cal_lo_ff)
              : 36'(cal_lo_ff) + (36'(d_rdg) * 36'(d_lev)) / 36'(d_span);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_ff <= `SPR_CAL_LO_RST;
      end else if (rdg_valid_i) begin
         if (lin < 36'(cal_lo_ff)) begin
            level_ff <= cal_lo_ff;
         end else if (lin > 36'(out_max)) begin
            level_ff <= out_max;
         end else begin
            level_ff <= 16'(lin);
         end
      end
   end

   // ==========================================================
   // Outputs.
   assign dat_o          = dat_ff;
   assign ack_o          = ack_ff;
   assign relay_o        = {relay_ff, relay1_ff};
   assign led_o          = {relay_ff, relay1_ff};
   assign bar_col_o      = col_ff;
   assign bar_center_o   = ctrl_ff.center;
   assign bar_up_o       = bar_up_ff;
   assign readout_on_o   = readout_ff;
   assign edit_digit_o   = (ed_ff == SPR_ED_EDIT) ? 4'(4'h1 << ed_idx_ff) : 4'h0;
   assign skip_out_cal_o = cap_done_ff && !fitted_ff;
   assign out_level_o    = level_ff;

   // ==========================================================
   // Checks.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_edit_on_last;
      ed_ff == SPR_ED_EDIT && ed_idx_ff == 2'h3 ##0 pol_next_i;
   endsequence

   a_center_dir: assert property (rdg_valid_i |=> bar_up_o == ($past(rdg_i) >= 0))
      else $error("bar direction wrong");
   a_readout_relit: assert property (btn_press_i |=> readout_on_o [*1])
      else $error("readout not relit");
   a_detect_hold: assert property (cap_done_ff |=> $stable(skip_out_cal_o))
      else $error("module detect changed");
   a_cal_lo_refuse: assert property (wr && hit(adr_i, `SPR_ADR_CAL_LO) && !lo_ok
                                     |=> $stable(cal_lo_ff) && cal_rej_ff)
      else $error("bad low level taken");
   a_out_floor: assert property (rdg_valid_i |=> out_level_o >= $past(cal_lo_ff))
      else $error("output under low level");
   a_make_wait: assert property ($rose(relay1_ff)
                                 |-> $past(raw1_ff && dly_cnt_ff >= make_ff))
      else $error("relay made early");
   a_sp3_direct: assert property (rdg_valid_i && ctrl_ff.pol_high[2] && rdg_i > sp_ff[2]
                                  |=> relay_o[2])
      else $error("setpoint three late");
   a_band_fill: assert property (rdg_valid_i && band_on && !ctrl_ff.pol_high[0]
                                 && rdg_i < sp_ff[0] |=> raw1_ff ##1 1'b1)
      else $error("fill band not on");
   a_tie_colour: assert property (rdg_valid_i && sp_ff[2] == sp_ff[3] && rdg_i > sp_ff[3]
                                  && sp_ff[3] >= sp_ff[0] && sp_ff[3] >= sp_ff[1]
                                  |=> bar_col_o == $past(ctrl_ff.sp_col[3]))
      else $error("tie colour wrong");
   a_edit_end: assert property (s_edit_on_last
                                |=> ed_ff == SPR_ED_IDLE && edit_digit_o == 4'h0)
      else $error("editor did not end");

endmodule

`default_nettype wire

/* bench/spr_panel_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// Front panel model: registers bench requests onto the button pulse lines, one cycle late.
module spr_panel_model (
   // Clock.
   input  wire logic       clk_i,
   // Requests: bit0 press, bit1 done, bit2 start, bit3 flip, bit4 next.
   input  wire logic [4:0] req_i,
   // Panel pulses and output module detect.
   output logic            btn_press_o,
   output logic            proc_done_o,
   output logic            pol_edit_start_o,
   output logic            pol_flip_o,
   output logic            pol_next_o,
   output logic            out_fitted_o
);
   // The output module is left out so that the calibration skip shows.
   assign out_fitted_o = 1'b0;
   // Each request bit is registered straight onto its pulse, one cycle later; a held request gives a held pulse.
   always_ff @(posedge clk_i) begin
      {pol_next_o, pol_flip_o, pol_edit_start_o, proc_done_o, btn_press_o} <= req_i;
   end
endmodule
`default_nettype wire

/* bench/tb_setpoint_relay_bargraph_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// Bench for the setpoint relay and bargraph controller.
module tb_setpoint_relay_bargraph_ctrl;
   import spr_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, rv = 0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, q, dat_o;
   logic [4:0] req = 5'h00;
   logic signed [15:0] rdg = 16'h0000, out_level_o;
   logic ack_o, bp, pd, ps, pf, pn, fit, bar_center_o, bar_up_o, ro, skip;
   logic [3:0] relay_o, led_o, ed;
   spr_col_t col;
   int n_fail = 0, tests_run = 0;
   always #5 clk_i = ~clk_i;
   spr_panel_model i_spr_panel_model (.clk_i(clk_i), .req_i(req), .btn_press_o(bp),
      .proc_done_o(pd), .pol_edit_start_o(ps), .pol_flip_o(pf), .pol_next_o(pn),
      .out_fitted_o(fit));
   // A short second keeps the delay tests within a few dozen cycles.
   spr_ctrl #(.SEC_CYCLES(10)) i_spr_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o),
      .ack_o(ack_o), .rdg_valid_i(rv), .rdg_i(rdg), .btn_press_i(bp), .proc_done_i(pd),
      .pol_edit_start_i(ps), .pol_flip_i(pf), .pol_next_i(pn), .out_fitted_i(fit),
      .relay_o(relay_o), .led_o(led_o), .bar_col_o(col), .bar_center_o(bar_center_o),
      .bar_up_o(bar_up_o), .readout_on_o(ro), .edit_digit_o(ed), .skip_out_cal_o(skip),
      .out_level_o(out_level_o));

   // Compare one value and count it.
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Classic single Wishbone cycle, held until ack is sampled high at a rising edge.
   // Only the watchdog ends a wait, so a slave that never answers fails the run.
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      q = dat_o;
      {cyc, stb} <= 2'b00;
   endtask
   // One new reading, then wait until its results have landed.
   task rd(input logic signed [15:0] v);
      @(posedge clk_i);
      {rv, rdg} <= {1'b1, v};
      @(posedge clk_i);
      rv <= 1'b0;
      repeat (2) @(negedge clk_i);
   endtask
   // One panel request through the partner model.
   task pnl(input logic [4:0] r);
      @(posedge clk_i);
      req <= r;
      @(posedge clk_i);
      req <= 5'h00;
      repeat (2) @(negedge clk_i);
   endtask

   task t_reset;
      wb(1'b0, 8'h00, 32'h0);
      chk("ctrl", q, 32'h0000_0F02);
      chk("skip", skip, 1'b1);
      $display("done reset");
   endtask
   task t_relays;
      wb(1'b1, 8'h04, 32'h0000_0064);
      wb(1'b1, 8'h14, 32'h0000_0002);
      wb(1'b1, 8'h0C, 32'h0000_0064);
      rd(16'sd200);
      chk("relay3", relay_o[2], 1'b1);
      repeat (10) @(negedge clk_i);
      chk("relay1 early", relay_o[0], 1'b0);
      repeat (20) @(negedge clk_i);
      chk("relay1 late", relay_o[0], 1'b1);
      wb(1'b1, 8'h18, 32'h0000_0001);
      rd(16'sd50);
      repeat (5) @(negedge clk_i);
      chk("relay1 held", relay_o[0], 1'b1);
      repeat (10) @(negedge clk_i);
      chk("relay1 broken", relay_o[0], 1'b0);
      $display("done relays");
   endtask
   task t_colour;
      wb(1'b1, 8'h08, 32'h0000_0064);
      wb(1'b1, 8'h00, 32'h0009_5F02);
      rd(16'sd150);
      chk("colour tie", col, SPR_RED);
      rd(16'sd50);
      chk("colour base", col, SPR_ORANGE);
      chk("relay3 off", relay_o[2], 1'b0);
      $display("done colour");
   endtask
   task t_output;
      rd(16'sd0);
      chk("out low", out_level_o, 16'h0FA0);
      rd(16'sd9999);
      chk("out high", out_level_o, 16'h4E20);
      chk("sp4 quiet", relay_o[3], 1'b0);
      rd(16'sd12000);
      chk("out above", out_level_o, 16'h5AA1);
      rd(-16'sd1000);
      chk("out clamp", out_level_o, 16'h0FA0);
      chk("bar down", bar_up_o, 1'b0);
      wb(1'b1, 8'h1C, 32'h0000_0064);
      wb(1'b0, 8'h2C, 32'h0);
      chk("cal reject", q[12], 1'b1);
      wb(1'b0, 8'h1C, 32'h0);
      chk("cal low kept", q, 32'h0000_0FA0);
      wb(1'b1, 8'h20, 32'h0000_61A8);
      wb(1'b0, 8'h20, 32'h0);
      chk("cal high kept", q, 32'h0000_4E20);
      wb(1'b1, 8'h20, 32'h0000_5DC0);
      wb(1'b0, 8'h20, 32'h0);
      chk("cal high taken", q, 32'h0000_5DC0);
      $display("done output");
   endtask
   task t_panel;
      pnl(5'h04);
      chk("digit one", ed, 4'h1);
      pnl(5'h08);
      pnl(5'h10);
      chk("digit two", ed, 4'h2);
      wb(1'b0, 8'h00, 32'h0);
      chk("flipped", q, 32'h0009_5E02);
      wb(1'b1, 8'h00, 32'h0009_5E01);
      chk("center", bar_center_o, 1'b1);
      pnl(5'h01);
      chk("lit", ro, 1'b1);
      pnl(5'h02);
      chk("blank", ro, 1'b0);
      repeat (3) pnl(5'h10);
      chk("edit end", ed, 4'h0);
      $display("done panel");
   endtask
   // Fill band on setpoint one with low polarity, no delays.
   task t_band;
      wb(1'b1, 8'h08, 32'h0000_00C8);
      wb(1'b1, 8'h14, 32'h0);
      wb(1'b1, 8'h18, 32'h0);
      wb(1'b1, 8'h00, 32'h0009_5EA5);
      wb(1'b0, 8'h00, 32'h0);
      chk("band enables", q, 32'h0009_5EA5);
      rd(16'sd50);
      chk("fill on", relay_o[0], 1'b1);
      rd(16'sd150);
      chk("fill hold", led_o[0], 1'b1);
      rd(16'sd250);
      chk("fill off", relay_o[0], 1'b0);
      rd(16'sd150);
      chk("stay off", led_o[0], 1'b0);
      $display("done band");
   endtask

   // Verdict and end of run.
   task final_report;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // The whole run needs well under a thousand cycles.
   initial begin
      #100000;
      n_fail++;
      final_report;
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(negedge clk_i);
      t_reset;
      t_relays;
      t_colour;
      t_output;
      t_panel;
      t_band;
      final_report;
   end
endmodule
`default_nettype wire
